// ==== logic/key_guard.sv ====
/*
  Key lifecycle guard of a self-encrypting drive: validation of the
  border secret value, key chaining, try limits, zeroization, tweak and
  IV generation and a two-entry buffer in front of the data cipher.
  Assumes external AES, SHA-256, HMAC, RSA and hash-DRBG engines behind
  the engine port, and non-volatile system storage behind the NV port.
*/
// Function
// - Volatile keys destroyed by zero overwrite
// - Non-volatile keys overwritten with fresh equal-size value
// - Erase also destroys all keys encrypting target
// - Destroy keying material once no longer needed
// - Compliant power entry destroys keys, border, factors
// - D0 and D3 are compliant states
// - RSA verify needs modulus of 2048+ bits
// - SHA-256 hashing service provided
// - HMAC-SHA-256 with 256-bit key
// - AES-256 key wrap in KW or GCM
// - User data AES-256 in XTS or GCM
// - All protected data encrypted, never plaintext
// - Border value 256+ bits, chained to data key
// - Intermediate key derived by HMAC password KDF
// - Hash DRBG seeded from 256-bit noise source
// - Salts from DRBG, no nonces used
// - XTS tweaks consecutive, no IV
// - GCM IV unique, at most 2^32 uses; a block taken at count 2^32-1 can still get IV 2^32, then input reopens
// - Validate by decrypting and comparing known value
// - Deny access until validated after power state
// - SATA: five failures block until reset
// - SAS: owner five, others 1024 failures block
// - Configurable threshold, data key replace and erase
`timescale 1ns/1ps
module key_guard (
  // Clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             SRST,
  // Pins from outside the clock domain
  input  wire logic [1:0]       PWR_STATE,
  input  wire logic             VARIANT_SAS,
  input  wire logic             NOISE_SEEDED,
  // Command channel
  input  wire logic             CMD_VALID,
  output logic                  CMD_READY,
  input  wire kg_pkg::cmd_t     CMD,
  output logic                  RSP_VALID,
  input  wire logic             RSP_READY,
  output kg_pkg::rsp_t          RSP,
  // Crypto engine
  output logic                  ENG_START,
  output kg_pkg::eng_req_t      ENG_REQ,
  input  wire logic             ENG_DONE,
  input  wire logic [255:0]     ENG_RESULT,
  // System storage
  input  wire logic [255:0]     SALT,
  input  wire logic [255:0]     KNOWN_CT,
  input  wire logic [255:0]     KNOWN_PT,
  input  wire logic [255:0]     WRAPPED_KEY,
  output logic                  NV_WR_VALID,
  input  wire logic             NV_WR_READY,
  output logic [255:0]          NV_WR_DATA,
  // User data stream
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  input  wire kg_pkg::blk_t     IN_BLK,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY,
  output kg_pkg::job_t          OUT_JOB,
  output logic [255:0]          DATA_KEY,
  // Status
  output logic                  KEY_LIVE,
  output logic                  UNLOCKED,
  output logic                  BLOCKED
);
  import kg_pkg::*;

  state_t s_q;
  state_t s_d;
  logic   push;
  logic   pop;
  logic   in_ok;
  logic   blk_now;
  logic   pwr_entry;
  logic   cmd_take;

  // ********************************
  // Handshakes and status
  // ********************************
  assign in_ok     = s_q.unlocked && s_q.key_live &&
                     !(s_q.gcm_mode && s_q.gcm_cnt == `KG_GCM_MAX);
  assign IN_READY  = in_ok && (s_q.cnt != `KG_BUF_FULL);
  assign OUT_VALID = s_q.key_live && (s_q.cnt != `KG_BUF_EMPTY);
  assign push      = IN_VALID && IN_READY;
  assign pop       = OUT_VALID && OUT_READY;
  assign CMD_READY = (s_q.fsm == ST_IDLE) && !s_q.rsp_valid;
  assign cmd_take  = CMD_VALID && CMD_READY;
  // Entry into a compliant state seen on the synchronised pins
  assign pwr_entry = (s_q.pwr_s2 != s_q.pwr_prev) &&
                     ((s_q.pwr_s2 == `KG_PS_D0) || (s_q.pwr_s2 == `KG_PS_D3));

  always_comb begin
    if (!s_q.sas_s2) begin
      blk_now = s_q.sata_blk;
    end else if (CMD.owner) begin
      blk_now = s_q.fail_owner >= `KG_OWNER_LIMIT;
    end else begin
      blk_now = s_q.fail_other >= s_q.limit;
    end
  end

  assign RSP_VALID   = s_q.rsp_valid;
  assign RSP         = s_q.rsp;
  assign ENG_START   = s_q.eng_start;
  assign ENG_REQ     = s_q.eng;
  assign NV_WR_VALID = s_q.nv_valid;
  assign NV_WR_DATA  = s_q.nv_data;
  assign DATA_KEY    = s_q.dkey;
  assign KEY_LIVE    = s_q.key_live;
  assign UNLOCKED    = s_q.unlocked;

  // Block status of the active variant's try limits
  always_comb begin
    if (!s_q.sas_s2) begin
      BLOCKED = s_q.sata_blk;
    end else begin
      BLOCKED = (s_q.fail_owner >= `KG_OWNER_LIMIT) || (s_q.fail_other >= s_q.limit);
    end
  end

  // ********************************
  // Data job toward the cipher
  // ********************************
  always_comb begin
    OUT_JOB       = '0;
    OUT_JOB.blk   = s_q.buffer[s_q.rp];
    OUT_JOB.gcm   = s_q.gcm_mode;
    OUT_JOB.tweak = s_q.gcm_mode ? '0 : s_q.tweak;
    OUT_JOB.iv    = s_q.gcm_mode ? `KG_IV_W'(s_q.gcm_cnt) : '0;
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    s_d           = s_q;
    s_d.eng_start = 1'b0;
    s_d.pwr_s1    = PWR_STATE;
    s_d.pwr_s2    = s_q.pwr_s1;
    s_d.pwr_prev  = s_q.pwr_s2;
    s_d.sas_s1    = VARIANT_SAS;
    s_d.sas_s2    = s_q.sas_s1;
    s_d.seed_s1   = NOISE_SEEDED;
    s_d.seed_s2   = s_q.seed_s1;

    // Two-entry buffer
    if (push) begin
      s_d.buffer[s_q.wp] = IN_BLK;
      s_d.wp             = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
      if (s_q.buffer[s_q.rp].last) begin
        if (s_q.gcm_mode) begin
          s_d.gcm_cnt = s_q.gcm_cnt + `KG_GCM_W'(1);
        end else begin
          s_d.tweak = s_q.tweak + `KG_TWK_W'(1);
        end
      end
    end
    case ({push, pop})
      2'b10:   s_d.cnt = s_q.cnt + 2'h1;
      2'b01:   s_d.cnt = s_q.cnt - 2'h1;
      default: s_d.cnt = s_q.cnt;
    endcase

    if (s_q.rsp_valid && RSP_READY) begin
      s_d.rsp_valid = 1'b0;
    end

    case (s_q.fsm)
      ST_IDLE: begin
        if (cmd_take) begin
          s_d.cmd       = CMD;
          s_d.rsp       = '0;
          s_d.rsp_valid = 1'b1;
          case (CMD.op)
            CMD_VALIDATE: begin
              if (blk_now) begin
                s_d.rsp.blocked = 1'b1;
              end else if (CMD.len >= `KG_BORDER_MIN) begin
                s_d.border    = CMD.arg;
                s_d.eng       = '{ENG_KDF, CMD.arg, SALT};
                s_d.eng_start = 1'b1;
                s_d.rsp_valid = 1'b0;
                s_d.fsm       = ST_KDF;
              end
            end
            CMD_ERASE: begin
              s_d.dkey     = `KG_ZERO_KEY;
              s_d.inter    = `KG_ZERO_KEY;
              s_d.key_live = 1'b0;
              s_d.unlocked = 1'b0;
              s_d.cnt      = `KG_BUF_EMPTY;
              if (s_q.seed_s2) begin
                s_d.eng       = '{ENG_RAND, `KG_ZERO_KEY, `KG_ZERO_KEY};
                s_d.eng_start = 1'b1;
                s_d.rsp_valid = 1'b0;
                s_d.fsm       = ST_RAND;
              end
            end
            CMD_REKEY: begin
              if (s_q.unlocked && s_q.seed_s2) begin
                s_d.eng       = '{ENG_RAND, `KG_ZERO_KEY, `KG_ZERO_KEY};
                s_d.eng_start = 1'b1;
                s_d.rsp_valid = 1'b0;
                s_d.fsm       = ST_RAND;
              end
            end
            CMD_LIMIT: begin
              s_d.limit  = CMD.arg[`KG_CNT_W-1:0];
              s_d.rsp.ok = 1'b1;
            end
            CMD_MODE: begin
              s_d.gcm_mode = CMD.arg[0];
              s_d.rsp.ok   = 1'b1;
            end
            CMD_HASH: begin
              s_d.eng       = '{ENG_HASH, `KG_ZERO_KEY, CMD.msg};
              s_d.eng_start = 1'b1;
              s_d.rsp_valid = 1'b0;
              s_d.fsm       = ST_SVC;
            end
            CMD_HMAC: begin
              s_d.eng       = '{ENG_HMAC, CMD.arg, CMD.msg};
              s_d.eng_start = 1'b1;
              s_d.rsp_valid = 1'b0;
              s_d.fsm       = ST_SVC;
            end
            CMD_SIGVER: begin
              if (CMD.len >= `KG_RSA_MIN_BITS) begin
                s_d.eng       = '{ENG_RSAV, CMD.arg, CMD.msg};
                s_d.eng_start = 1'b1;
                s_d.rsp_valid = 1'b0;
                s_d.fsm       = ST_SVC;
              end
            end
            default: s_d.rsp_valid = 1'b1;
          endcase
        end
      end
      ST_KDF: begin
        if (ENG_DONE) begin
          s_d.inter     = ENG_RESULT;
          s_d.border    = `KG_ZERO_KEY;
          s_d.eng       = '{ENG_DECK, ENG_RESULT, KNOWN_CT};
          s_d.eng_start = 1'b1;
          s_d.fsm       = ST_DECK;
        end
      end
      ST_DECK: begin
        if (ENG_DONE) begin
          if (ENG_RESULT == KNOWN_PT) begin
            s_d.eng       = '{ENG_UNWRAP, s_q.inter, WRAPPED_KEY};
            s_d.eng_start = 1'b1;
            s_d.fsm       = ST_UNWRAP;
            if (s_q.cmd.owner) begin
              s_d.fail_owner = '0;
            end else begin
              s_d.fail_other = '0;
            end
          end else begin
            s_d.inter     = `KG_ZERO_KEY;
            s_d.rsp_valid = 1'b1;
            s_d.fsm       = ST_IDLE;
            if (s_q.cmd.owner && s_q.sas_s2) begin
              if (s_q.fail_owner != '1) begin
                s_d.fail_owner = s_q.fail_owner + `KG_CNT_W'(1);
              end
            end else if (s_q.fail_other != '1) begin
              s_d.fail_other = s_q.fail_other + `KG_CNT_W'(1);
            end
            if (!s_q.sas_s2 && (s_q.fail_other + `KG_CNT_W'(1) >= `KG_SATA_LIMIT)) begin
              s_d.sata_blk = 1'b1;
            end
          end
        end
      end
      ST_UNWRAP: begin
        if (ENG_DONE) begin
          s_d.dkey      = ENG_RESULT;
          s_d.key_live  = 1'b1;
          s_d.unlocked  = 1'b1;
          s_d.rsp.ok    = 1'b1;
          s_d.rsp_valid = 1'b1;
          s_d.fsm       = ST_IDLE;
        end
      end
      ST_RAND: begin
        if (ENG_DONE) begin
          if (s_q.cmd.op == CMD_REKEY) begin
            s_d.dkey      = ENG_RESULT;
            s_d.gcm_cnt   = '0;
            s_d.eng       = '{ENG_WRAP, s_q.inter, ENG_RESULT};
            s_d.eng_start = 1'b1;
            s_d.fsm       = ST_WRAP;
          end else begin
            s_d.nv_data  = ENG_RESULT;
            s_d.nv_valid = 1'b1;
            s_d.fsm      = ST_NVW;
          end
        end
      end
      ST_WRAP: begin
        if (ENG_DONE) begin
          s_d.nv_data  = ENG_RESULT;
          s_d.nv_valid = 1'b1;
          s_d.fsm      = ST_NVW;
        end
      end
      ST_NVW: begin
        if (NV_WR_READY) begin
          s_d.nv_valid  = 1'b0;
          s_d.nv_data   = `KG_ZERO_KEY;
          s_d.rsp.ok    = 1'b1;
          s_d.rsp_valid = 1'b1;
          s_d.fsm       = ST_IDLE;
        end
      end
      ST_SVC: begin
        if (ENG_DONE) begin
          s_d.rsp.ok    = (s_q.cmd.op == CMD_SIGVER) ? ENG_RESULT[0] : 1'b1;
          s_d.rsp.data  = ENG_RESULT;
          s_d.rsp_valid = 1'b1;
          s_d.fsm       = ST_IDLE;
        end
      end
      default: s_d.fsm = ST_IDLE;
    endcase

    // Compliant power entry wipes every plaintext key and factor; buffered data blocks are dropped
    if (pwr_entry) begin
      s_d.border    = `KG_ZERO_KEY;
      s_d.inter     = `KG_ZERO_KEY;
      s_d.dkey      = `KG_ZERO_KEY;
      s_d.cmd       = '0;
      s_d.eng       = '0;
      s_d.eng_start = 1'b0;
      s_d.nv_valid  = 1'b0;
      s_d.nv_data   = `KG_ZERO_KEY;
      s_d.rsp       = '0;
      s_d.rsp_valid = 1'b0;
      s_d.key_live  = 1'b0;
      s_d.unlocked  = 1'b0;
      s_d.cnt       = `KG_BUF_EMPTY;
      s_d.wp        = 1'b0;
      s_d.rp        = 1'b0;
      s_d.fsm       = ST_IDLE;
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      s_q       <= '0;
      s_q.fsm   <= ST_IDLE;
      s_q.limit <= `KG_OTHER_LIMIT;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ==== logic/key_guard_defines.svh ====
/*
  Widths, limits, power codes and reset values of the key guard.
  Assumes it is included by the key guard package only.
*/
`ifndef KEY_GUARD_DEFINES_SVH
`define KEY_GUARD_DEFINES_SVH

`define KG_KEY_W        256
`define KG_BLK_W        128
`define KG_TWK_W        64
`define KG_IV_W         96
`define KG_CNT_W        11
`define KG_GCM_W        33
`define KG_LEN_W        16
`define KG_PS_W         2
`define KG_OWNER_LIMIT  11'h005
`define KG_SATA_LIMIT   11'h005
`define KG_OTHER_LIMIT  11'h400
`define KG_GCM_MAX      33'h100000000
`define KG_RSA_MIN_BITS 16'h0800
`define KG_BORDER_MIN   16'h0100
`define KG_PS_D0        2'h0
`define KG_PS_D3        2'h3
`define KG_ZERO_KEY     256'h0
`define KG_BUF_FULL     2'h2
`define KG_BUF_EMPTY    2'h0

`endif

// ==== logic/kg_pkg.sv ====
/*
  Types of the key guard: commands, answers, engine requests,
  data jobs and the packed state.
  Assumes key_guard_defines.svh sits on the include path.
*/
package kg_pkg;
  `include "key_guard_defines.svh"

  typedef enum logic [3:0] {
    CMD_VALIDATE = 4'h0, CMD_ERASE = 4'h1, CMD_REKEY = 4'h2, CMD_LIMIT = 4'h3,
    CMD_MODE     = 4'h4, CMD_HASH  = 4'h5, CMD_HMAC  = 4'h6, CMD_SIGVER = 4'h7
  } cmd_op_t;

  typedef enum logic [2:0] {
    ENG_KDF  = 3'h0, ENG_DECK = 3'h1, ENG_UNWRAP = 3'h2, ENG_WRAP = 3'h3,
    ENG_RAND = 3'h4, ENG_HASH = 3'h5, ENG_HMAC   = 3'h6, ENG_RSAV = 3'h7
  } eng_op_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_KDF = 8'h02, ST_DECK = 8'h04, ST_UNWRAP = 8'h08,
    ST_RAND = 8'h10, ST_WRAP = 8'h20, ST_NVW = 8'h40, ST_SVC = 8'h80
  } fsm_t;

  typedef struct packed {
    cmd_op_t               op;
    logic                  owner;
    logic [`KG_LEN_W-1:0]  len;
    logic [`KG_KEY_W-1:0]  arg;
    logic [`KG_KEY_W-1:0]  msg;
  } cmd_t;

  typedef struct packed {
    logic                  ok;
    logic                  blocked;
    logic [`KG_KEY_W-1:0]  data;
  } rsp_t;

  typedef struct packed {
    eng_op_t               op;
    logic [`KG_KEY_W-1:0]  key;
    logic [`KG_KEY_W-1:0]  data;
  } eng_req_t;

  typedef struct packed {
    logic [`KG_BLK_W-1:0]  data;
    logic                  last;
  } blk_t;

  typedef struct packed {
    blk_t                  blk;
    logic                  gcm;
    logic [`KG_TWK_W-1:0]  tweak;
    logic [`KG_IV_W-1:0]   iv;
  } job_t;

  typedef struct packed {
    fsm_t                  fsm;
    cmd_t                  cmd;
    logic [`KG_KEY_W-1:0]  border;
    logic [`KG_KEY_W-1:0]  inter;
    logic [`KG_KEY_W-1:0]  dkey;
    logic                  key_live;
    logic                  unlocked;
    logic [`KG_CNT_W-1:0]  fail_owner;
    logic [`KG_CNT_W-1:0]  fail_other;
    logic [`KG_CNT_W-1:0]  limit;
    logic                  sata_blk;
    logic                  gcm_mode;
    logic [`KG_TWK_W-1:0]  tweak;
    logic [`KG_GCM_W-1:0]  gcm_cnt;
    logic [`KG_PS_W-1:0]   pwr_s1;
    logic [`KG_PS_W-1:0]   pwr_s2;
    logic [`KG_PS_W-1:0]   pwr_prev;
    logic                  sas_s1;
    logic                  sas_s2;
    logic                  seed_s1;
    logic                  seed_s2;
    blk_t [1:0]            buffer;
    logic [1:0]            cnt;
    logic                  wp;
    logic                  rp;
    logic                  eng_start;
    eng_req_t              eng;
    logic                  nv_valid;
    logic [`KG_KEY_W-1:0]  nv_data;
    logic                  rsp_valid;
    rsp_t                  rsp;
  } state_t;
endpackage

// ==== verif/key_guard_assertions.sv ====
/*
  Concurrent checks on the ports of the key guard.
  Assumes it is bound into every key_guard instance.
*/
`timescale 1ns/1ps
module key_guard_checker (
  // Clock and reset
  input wire logic             CORE_CLK,
  input wire logic             SRST,
  // Observed ports
  input wire logic [1:0]       PWR_STATE,
  input wire logic             IN_VALID,
  input wire logic             IN_READY,
  input wire logic             OUT_VALID,
  input wire logic             OUT_READY,
  input wire kg_pkg::job_t     OUT_JOB,
  input wire logic [255:0]     DATA_KEY,
  input wire logic             KEY_LIVE,
  input wire logic             UNLOCKED,
  input wire logic             BLOCKED,
  input wire logic             RSP_VALID,
  input wire kg_pkg::rsp_t     RSP
);
  import kg_pkg::*;
  // ********************
  // Port checks
  // ********************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  key_zero_a: assert property (
    !KEY_LIVE |-> DATA_KEY == 256'h0) else $error("Data key held while not live");
  locked_in_a: assert property (
    !UNLOCKED |-> !IN_READY) else $error("Stream taken while locked");
  dead_in_a: assert property (
    !KEY_LIVE |-> !IN_READY) else $error("Stream taken without key");
  push_out_a: assert property (
    IN_VALID && IN_READY |=> OUT_VALID) else $error("Taken word not offered");
  hold_out_a: assert property (
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_JOB))
    else $error("Stalled job changed");
  tweak_step_a: assert property (
    (OUT_VALID && OUT_READY && OUT_JOB.blk.last && !OUT_JOB.gcm) ##1 (OUT_VALID && !OUT_JOB.gcm)
    |-> OUT_JOB.tweak == $past(OUT_JOB.tweak) + 64'h1) else $error("Tweak not consecutive");
  blk_ok_a: assert property (
    RSP_VALID && RSP.blocked |-> !RSP.ok) else $error("Blocked answer with success");
  blk_stay_a: assert property (
    BLOCKED |=> BLOCKED) else $error("Block released without reset");
  pwr_wipe_a: assert property (
    $changed(PWR_STATE) && (PWR_STATE == 2'h0 || PWR_STATE == 2'h3)
    |-> ##[2:5] (!UNLOCKED && !KEY_LIVE && DATA_KEY == 256'h0))
    else $error("Keys kept after power state entry");
  cover property (RSP_VALID && RSP.ok);
  cover property (BLOCKED);
  cover property (IN_VALID && !IN_READY && UNLOCKED);
endmodule

bind key_guard key_guard_checker i_key_guard_checker (.CORE_CLK, .SRST, .PWR_STATE, .IN_VALID,
  .IN_READY, .OUT_VALID, .OUT_READY, .OUT_JOB, .DATA_KEY, .KEY_LIVE, .UNLOCKED, .BLOCKED,
  .RSP_VALID, .RSP);

// ==== verif/eng_store_model.sv ====
/*
  Crypto engine and system storage model: every engine op except a random
  draw answers with key xor data, random draws are slow and fresh; writes get one ready.
  Assumes the key guard clock and reset.
*/
`timescale 1ns/1ps
module eng_store_model (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Engine side
  input  wire logic             start,
  input  wire kg_pkg::eng_req_t req,
  output logic                  done,
  output logic [255:0]          result,
  // Storage side
  input  wire logic             nv_valid,
  output logic                  nv_ready
);
  import kg_pkg::*;
  eng_req_t    req_q;
  logic        busy_q;
  logic [2:0]  wait_q;
  logic [31:0] rnd_q;
  // ********************
  // Engine answers
  // ********************
  always_ff @(posedge clk) begin
    done <= 1'b0;
    result <= ~result;
    nv_ready <= nv_valid && !nv_ready;
    if (srst) begin
      busy_q <= 1'b0;
      rnd_q <= 32'h1;
      result <= 256'h0;
      nv_ready <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      req_q <= req;
      wait_q <= (req.op == ENG_RAND) ? 3'h4 : 3'h0;
    end else if (busy_q && wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      done <= 1'b1;
      if (req_q.op == ENG_RAND) begin
        result <= {8{rnd_q}};
        rnd_q <= rnd_q + 32'h1;
      end else begin
        result <= req_q.key ^ req_q.data;
      end
    end
  end
endmodule

// ==== verif/key_guard_test.sv ====
/*
  Scenario bench of the key guard: unlock, try limits, stream buffer,
  power wipe and erase.
  Assumes the engine and storage model and the bound checker.
*/
`timescale 1ns/1ps
module key_guard_test;
  import kg_pkg::*;
  localparam logic [255:0] PASS_W = 256'h1357_9BDF_2468_ACE0;
  logic CORE_CLK, SRST, VARIANT_SAS, NOISE_SEEDED, CMD_VALID, CMD_READY, RSP_VALID, RSP_READY;
  logic ENG_START, ENG_DONE, NV_WR_VALID, NV_WR_READY, IN_VALID, IN_READY, OUT_VALID;
  logic OUT_READY, KEY_LIVE, UNLOCKED, BLOCKED;
  logic [1:0] PWR_STATE;
  logic [255:0] ENG_RESULT, SALT, KNOWN_CT, KNOWN_PT, WRAPPED_KEY, NV_WR_DATA, DATA_KEY, nv_seen;
  cmd_t CMD;
  rsp_t RSP, r;
  eng_req_t ENG_REQ;
  blk_t IN_BLK;
  job_t OUT_JOB;
  int miscompares, total_checks, cycles;
  key_guard i_key_guard (.CORE_CLK, .SRST, .PWR_STATE, .VARIANT_SAS, .NOISE_SEEDED, .CMD_VALID,
    .CMD_READY, .CMD, .RSP_VALID, .RSP_READY, .RSP, .ENG_START, .ENG_REQ, .ENG_DONE,
    .ENG_RESULT, .SALT, .KNOWN_CT, .KNOWN_PT, .WRAPPED_KEY, .NV_WR_VALID, .NV_WR_READY,
    .NV_WR_DATA, .IN_VALID, .IN_READY, .IN_BLK, .OUT_VALID, .OUT_READY, .OUT_JOB, .DATA_KEY,
    .KEY_LIVE, .UNLOCKED, .BLOCKED);
  eng_store_model i_eng_store_model (.clk(CORE_CLK), .srst(SRST), .start(ENG_START),
    .req(ENG_REQ), .done(ENG_DONE), .result(ENG_RESULT), .nv_valid(NV_WR_VALID),
    .nv_ready(NV_WR_READY));
  // ********************
  // Clock, watchdog, helpers
  // ********************
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    cycles++;
    if (NV_WR_VALID && NV_WR_READY) nv_seen = NV_WR_DATA;
    if (cycles == 20000) begin
      miscompares++;
      final_report;
    end
  end
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [255:0] exp, input logic [255:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic do_reset;
    SRST <= 1'b1;
    repeat (6) @(posedge CORE_CLK);
    SRST <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
  endtask
  task automatic cmd(input cmd_op_t op, input logic [255:0] a, input logic ow,
                     input logic [15:0] ln);
    CMD_VALID <= 1'b1;
    CMD <= {op, ow, ln, a, ~a};
    do @(posedge CORE_CLK); while (!CMD_READY);
    CMD_VALID <= 1'b0;
    do @(posedge CORE_CLK); while (!RSP_VALID);
    r = RSP;
  endtask
  task automatic val_bad(input int n, input logic ow);
    repeat (n) cmd(CMD_VALIDATE, ~PASS_W, ow, 16'h0100);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    chk("cmd ready", 1, CMD_READY);
    chk("data key", 0, DATA_KEY);
    IN_VALID <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    chk("locked in ready", 0, IN_READY);
    IN_VALID <= 1'b0;
  endtask
  task automatic t_unlock;
    cmd(CMD_VALIDATE, PASS_W, 1'b0, 16'h00FF);
    chk("short border ok", 0, r.ok);
    val_bad(3, 1'b0);
    cmd(CMD_VALIDATE, PASS_W, 1'b0, 16'h0100);
    chk("validate ok", 1, r.ok);
    chk("chained key", PASS_W ^ SALT ^ WRAPPED_KEY, DATA_KEY);
    val_bad(4, 1'b0);
    chk("count cleared", 0, BLOCKED);
    cmd(CMD_VALIDATE, PASS_W, 1'b0, 16'h0100);
    chk("unlocked", 1, UNLOCKED);
  endtask
  task automatic t_stream;
    int n;
    logic [63:0] tw[2];
    logic [127:0] dt[2];
    n = 0;
    IN_VALID <= 1'b1;
    IN_BLK <= {128'h1, 1'b1};
    repeat (6) begin
      @(posedge CORE_CLK);
      if (IN_VALID && IN_READY) begin
        n++;
        IN_BLK <= {128'(n + 1), 1'b1};
      end
    end
    IN_VALID <= 1'b0;
    chk("buffered words", 2, n);
    OUT_READY <= 1'b1;
    n = 0;
    repeat (4) begin
      @(posedge CORE_CLK);
      if (OUT_VALID && OUT_READY && n < 2) begin
        tw[n] = OUT_JOB.tweak;
        dt[n] = OUT_JOB.blk.data;
        n++;
      end
    end
    chk("first word", 128'h1, dt[0]);
    chk("second word", 128'h2, dt[1]);
    chk("tweak step", tw[0] + 64'h1, tw[1]);
    chk("drained", 0, OUT_VALID);
  endtask
  task automatic t_svc;
    cmd(CMD_HASH, PASS_W, 1'b0, 16'h0);
    chk("hash digest", ~PASS_W, r.data);
    cmd(CMD_HMAC, PASS_W, 1'b0, 16'h0);
    chk("mac value", ~256'h0, r.data);
    cmd(CMD_SIGVER, PASS_W, 1'b0, 16'h07FF);
    chk("short modulus ok", 0, r.ok);
    cmd(CMD_SIGVER, PASS_W, 1'b0, 16'h0800);
    chk("long modulus ok", 1, r.ok);
    nv_seen = 256'h0;
    cmd(CMD_REKEY, 256'h0, 1'b0, 16'h0);
    chk("rekey ok", 1, r.ok);
    chk("new data key", {8{32'h1}}, DATA_KEY);
    chk("wrapped new key", PASS_W ^ SALT ^ {8{32'h1}}, nv_seen);
    cmd(CMD_MODE, 256'h1, 1'b0, 16'h0);
    IN_BLK <= {128'h5, 1'b1};
    for (int i = 0; i < 2; i++) begin
      IN_VALID <= 1'b1;
      @(posedge CORE_CLK);
      IN_VALID <= 1'b0;
      @(posedge CORE_CLK);
      chk("gcm job", 1, OUT_VALID && OUT_JOB.gcm);
      chk("gcm iv", i, OUT_JOB.iv);
    end
  endtask
  task automatic t_power;
    PWR_STATE <= 2'h2;
    repeat (6) @(posedge CORE_CLK);
    chk("other state kept", 1, UNLOCKED);
    PWR_STATE <= 2'h3;
    repeat (6) @(posedge CORE_CLK);
    chk("wiped unlock", 0, UNLOCKED);
    chk("wiped key", 0, DATA_KEY);
    PWR_STATE <= 2'h0;
    repeat (6) @(posedge CORE_CLK);
    cmd(CMD_VALIDATE, PASS_W, 1'b0, 16'h0100);
    chk("revalidate", 1, r.ok);
  endtask
  task automatic t_erase;
    logic [255:0] k;
    k = DATA_KEY;
    NOISE_SEEDED <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    cmd(CMD_ERASE, 256'h0, 1'b0, 16'h0);
    chk("unseeded erase ok", 0, r.ok);
    chk("unseeded erase key", 0, DATA_KEY);
    NOISE_SEEDED <= 1'b1;
    nv_seen = 256'h0;
    repeat (3) @(posedge CORE_CLK);
    cmd(CMD_ERASE, 256'h0, 1'b0, 16'h0);
    chk("erase ok", 1, r.ok);
    chk("erase live", 0, KEY_LIVE);
    chk("fresh overwrite", 1, nv_seen !== 256'h0 && nv_seen !== k);
  endtask
  task automatic t_block;
    cmd(CMD_VALIDATE, PASS_W, 1'b0, 16'h0100);
    val_bad(5, 1'b0);
    chk("sata blocked", 1, BLOCKED);
    cmd(CMD_VALIDATE, PASS_W, 1'b0, 16'h0100);
    chk("refused ok", 0, r.ok);
    chk("refused flag", 1, r.blocked);
  endtask
  task automatic t_sas;
    VARIANT_SAS <= 1'b1;
    do_reset;
    chk("reset unblocks", 0, BLOCKED);
    cmd(CMD_LIMIT, 256'h2, 1'b0, 16'h0);
    val_bad(1, 1'b0);
    chk("below limit", 0, BLOCKED);
    val_bad(1, 1'b0);
    chk("at set limit", 1, BLOCKED);
    do_reset;
    val_bad(4, 1'b1);
    chk("owner four", 0, BLOCKED);
    val_bad(1, 1'b1);
    chk("owner five", 1, BLOCKED);
  endtask
  initial begin
    SRST = 1'b1;
    PWR_STATE = 2'h0;
    VARIANT_SAS = 1'b0;
    NOISE_SEEDED = 1'b1;
    CMD_VALID = 1'b0;
    CMD = '0;
    RSP_READY = 1'b1;
    IN_VALID = 1'b0;
    IN_BLK = '0;
    OUT_READY = 1'b0;
    SALT = 256'h5A5A_0F0F;
    KNOWN_CT = 256'hC3C3_9999;
    KNOWN_PT = PASS_W ^ SALT ^ KNOWN_CT;
    WRAPPED_KEY = 256'h7E57_0001_BEEF;
    do_reset;
    t_reset;
    t_unlock;
    t_stream;
    t_svc;
    t_power;
    t_erase;
    t_block;
    t_sas;
    final_report;
  end
endmodule
